/* File: hw/display_output_control.sv */
// Notes on behaviour
// [RULE_01] clearing vertical irq enable drops pending interrupt
// [RULE_02] enabled vertical irq fires at next vsync
// [RULE_03] timing signals only while generator enabled
// [RULE_04] generator off: pixel logic reset, timing writable
// [RULE_05] generator on: timing registers cannot change
// [RULE_06] serial clock bit drives vsync pin when disabled
// [RULE_07] software disables vsync, then toggles serial clock
// [RULE_08] blank enable off holds display enable low
// [RULE_09] hsync enable off holds crt hsync low
// [RULE_10] vsync enable off drives crt_vertical_sync_pin from the serial clock bit
// [RULE_11] panel syncs ignore crt enables, follow power logic
// [RULE_12] pixel port enables/disables on bit 0 edges
// [RULE_13] output config at 830c, writes need lock released
// [RULE_14] low twenty output config bits reset zero
// [RULE_15] diagnostic bit opens buffer, rise resets pointer
// [RULE_16] bit 14 selects read or write buffer address
// [RULE_17] locked timing writes dropped without error
//
// The AXI4-Lite slave port was chosen for this implementation.
module display_output_control
	import display_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// axi4-lite write address and data
	input  wire logic [15:0] s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	// axi4-lite read
	input  wire logic [15:0] s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// panel power sequencing
	input  wire logic        panel_power_on_in,
	// display pins
	input  wire logic        serial_id_data_in,
	output logic             crt_hsync_out,
	output logic             crt_vertical_sync_pin_out,
	output logic             display_enable_out,
	output logic             panel_hsync_out,
	output logic             panel_vsync_out,
	output logic             pixel_port_enable_out,
	// compressed line buffer control
	output logic             line_buffer_line_buffer_mode_a_out,
	output logic             line_buffer_use_read_addr_out,
	output logic             line_buffer_wptr_reset_out,
	// interrupt
	output logic             irq_out
);
	logic                           locked;
	logic [GEN_CONFIG_WIDTH-1:0]    gen_config;
	logic [OUTPUT_CONFIG_WIDTH-1:0] display_output_config;
	logic [TIMING_WIDTH-1:0]        h_timing;
	logic [TIMING_WIDTH-1:0]        v_timing;
	logic [IRQ_WIDTH-1:0]           irq_status;
	logic [IRQ_WIDTH-1:0]           irq_mask;
	logic                           aw_held;
	logic                           w_held;
	logic [15:0]                    aw_addr;
	logic [31:0]                    w_data;
	logic [3:0]                     w_strb;
	logic                           vsync_d;
	logic                           serial_id_level;

	wire [TIMING_FIELD_WIDTH-1:0] h_count;
	wire [TIMING_FIELD_WIDTH-1:0] v_count;
	wire                          h_wrap;
	wire                          v_wrap;

	// bus handshakes
	wire do_write = aw_held && w_held && !s_axi_bvalid_out;
	wire do_read  = s_axi_arvalid_in && !s_axi_rvalid_out;
	assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
	assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
	assign s_axi_arready_out = !s_axi_rvalid_out;

	// byte-lane merge of the pending write
	wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask, input logic [31:0] data);
		merge = (old & ~mask) | (data & mask);
	endfunction : merge

	// write decode; the lock and the timing enable gate what actually lands
	wire hit_lock    = (aw_addr == OFFSET_LOCK);
	wire hit_gen     = (aw_addr == OFFSET_GEN_CONFIG);
	wire hit_out     = (aw_addr == OFFSET_OUTPUT_CONFIG);
	wire hit_h       = (aw_addr == OFFSET_H_TIMING);
	wire hit_v       = (aw_addr == OFFSET_V_TIMING);
	wire hit_status  = (aw_addr == OFFSET_IRQ_STATUS);
	wire hit_mask    = (aw_addr == OFFSET_IRQ_MASK);
	wire hit_line    = (aw_addr == OFFSET_LINE_STATUS);
	wire write_known = hit_lock | hit_gen | hit_out | hit_h | hit_v | hit_status | hit_mask | hit_line;
	wire tg_enabled  = gen_config[BIT_TIMING_GEN_ENABLE];
	wire wr_gen      = do_write && hit_gen && !locked;
	wire wr_out      = do_write && hit_out && !locked;                                // RULE_13
	wire timing_open = !locked && !tg_enabled;                                         // RULE_05
	wire wr_h        = do_write && hit_h && timing_open;                               // RULE_04
	wire wr_v        = do_write && hit_v && timing_open;                               // RULE_17

	wire [31:0] gen_merged = merge({25'h0, gen_config}, strb_mask, w_data);
	wire [31:0] out_merged = merge({12'h0, display_output_config}, strb_mask, w_data);
	wire [31:0] h_merged   = merge({2'h0, h_timing}, strb_mask, w_data);
	wire [31:0] v_merged   = merge({2'h0, v_timing}, strb_mask, w_data);
	wire [GEN_CONFIG_WIDTH-1:0]    next_gen_config = gen_merged[GEN_CONFIG_WIDTH-1:0];
	wire [OUTPUT_CONFIG_WIDTH-1:0] next_out_config = out_merged[OUTPUT_CONFIG_WIDTH-1:0];

	// edge detection on software writes
	wire pixel_port_rise = wr_gen && !gen_config[BIT_PIXEL_PORT_ENABLE]
		&& next_gen_config[BIT_PIXEL_PORT_ENABLE];
	wire pixel_port_fall = wr_gen && gen_config[BIT_PIXEL_PORT_ENABLE]
		&& !next_gen_config[BIT_PIXEL_PORT_ENABLE];
	wire line_buffer_mode_a_rise = wr_out && !display_output_config[BIT_LINE_BUFFER_MODE_A]
		&& next_out_config[BIT_LINE_BUFFER_MODE_A];

	// pixel-domain timing; held in reset while the generator is off
	wire tg_hold = !tg_enabled;                                                        // RULE_04

	timing_counter #(
		.WIDTH (TIMING_FIELD_WIDTH)
	) h_counter (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.hold_in    (tg_hold),
		.advance_in (1'b1),
		.total_in   (h_timing[TIMING_TOTAL_LSB +: TIMING_FIELD_WIDTH]),
		.count_out  (h_count),
		.wrap_out   (h_wrap)
	);

	timing_counter #(
		.WIDTH (TIMING_FIELD_WIDTH)
	) v_counter (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.hold_in    (tg_hold),
		.advance_in (h_wrap),
		.total_in   (v_timing[TIMING_TOTAL_LSB +: TIMING_FIELD_WIDTH]),
		.count_out  (v_count),
		.wrap_out   (v_wrap)
	);

	input_sync3 serial_id_sync (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.async_in   (serial_id_data_in),
		.level_out  (serial_id_level)
	);

	// raw timing signals exist only while the generator runs
	wire h_active = (h_count < h_timing[TIMING_ACTIVE_LSB +: TIMING_FIELD_WIDTH]);
	wire v_active = (v_count < v_timing[TIMING_ACTIVE_LSB +: TIMING_FIELD_WIDTH]);
	wire h_sync   = tg_enabled && (h_count >= h_timing[TIMING_SYNC_LSB +: TIMING_FIELD_WIDTH]);  // RULE_03
	wire v_sync   = tg_enabled && (v_count >= v_timing[TIMING_SYNC_LSB +: TIMING_FIELD_WIDTH]);  // RULE_03
	wire active   = tg_enabled && h_active && v_active;                                          // RULE_03
	wire vsync_start = v_sync && !vsync_d;

	// crt_vertical_sync_pin pin carries the serial clock bit once vsync generation is off
	wire crt_vertical_sync_pin_en  = gen_config[BIT_CRT_VERTICAL_SYNC_PIN_ENABLE];
	wire next_crt_vpin = crt_vertical_sync_pin_en ? v_sync : gen_config[BIT_SERIAL_ID_CLOCK];               // RULE_06
	wire next_crt_hpin = gen_config[BIT_CRT_HSYNC_ENABLE] && h_sync;                            // RULE_09
	wire next_enable   = gen_config[BIT_BLANK_OUTPUT_ENABLE] && active;                         // RULE_08

	// interrupt events; a new event beats a simultaneous clear
	wire vie        = gen_config[BIT_VERT_IRQ_ENABLE];
	wire vie_clear  = wr_gen && !next_gen_config[BIT_VERT_IRQ_ENABLE];                          // RULE_01
	wire [IRQ_WIDTH-1:0] irq_set   = {v_wrap, vie && vsync_start};                              // RULE_02
	wire [IRQ_WIDTH-1:0] w1c       = (do_write && hit_status) ? w_data[IRQ_WIDTH-1:0] & {IRQ_WIDTH{w_strb[0]}}
		: {IRQ_WIDTH{1'b0}};
	wire [IRQ_WIDTH-1:0] irq_clear = w1c | {1'b0, vie_clear};
	wire [IRQ_WIDTH-1:0] next_irq_status = irq_set | (irq_status & ~irq_clear);

	assign irq_out = |(irq_status & irq_mask);

	// read decode
	wire [15:0] ra = s_axi_araddr_in;
	wire read_known = (ra == OFFSET_LOCK) | (ra == OFFSET_GEN_CONFIG) | (ra == OFFSET_OUTPUT_CONFIG)
		| (ra == OFFSET_H_TIMING) | (ra == OFFSET_V_TIMING) | (ra == OFFSET_IRQ_STATUS)
		| (ra == OFFSET_IRQ_MASK) | (ra == OFFSET_LINE_STATUS);
	wire [31:0] line_status = {serial_id_level, 9'h0, v_count, 2'h0, h_count};
	wire [31:0] read_value =
		(ra == OFFSET_LOCK)          ? {31'h0, locked} :
		(ra == OFFSET_GEN_CONFIG)    ? {25'h0, gen_config} :
		(ra == OFFSET_OUTPUT_CONFIG) ? {12'h0, display_output_config} :
		(ra == OFFSET_H_TIMING)      ? {2'h0, h_timing} :
		(ra == OFFSET_V_TIMING)      ? {2'h0, v_timing} :
		(ra == OFFSET_IRQ_STATUS)    ? {30'h0, irq_status} :
		(ra == OFFSET_IRQ_MASK)      ? {30'h0, irq_mask} :
		(ra == OFFSET_LINE_STATUS)   ? line_status : 32'h0;

	// bus channel state
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			aw_held          <= 1'b0;
			w_held           <= 1'b0;
			aw_addr          <= 16'h0;
			w_data           <= 32'h0;
			w_strb           <= 4'h0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr_in[15:2], 2'h0};
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
			end
			if (do_write) begin
				aw_held          <= 1'b0;
				w_held           <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= write_known ? RESP_OKAY : RESP_SLVERR;                // RULE_17
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= 32'h0;
			s_axi_rresp_out  <= RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out  <= read_value;
			s_axi_rresp_out  <= read_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// software registers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			locked                <= LOCKED_RESET;
			gen_config            <= GEN_CONFIG_RESET;
			display_output_config <= OUTPUT_CONFIG_RESET;                                   // RULE_14
			h_timing              <= TIMING_RESET;
			v_timing              <= TIMING_RESET;
			irq_mask              <= IRQ_RESET;
			irq_status            <= IRQ_RESET;
		end else begin
			irq_status <= next_irq_status;
			if (do_write && hit_lock) begin
				locked <= (w_data != UNLOCK_KEY);
			end
			if (wr_gen) begin
				gen_config <= next_gen_config;
			end
			if (wr_out) begin
				display_output_config <= next_out_config;                                 // RULE_13
			end
			if (wr_h) begin
				h_timing <= h_merged[TIMING_WIDTH-1:0];                                   // RULE_05
			end
			if (wr_v) begin
				v_timing <= v_merged[TIMING_WIDTH-1:0];                                   // RULE_05
			end
			if (do_write && hit_mask) begin
				irq_mask <= w_data[IRQ_WIDTH-1:0];
			end
		end
	end

	// registered pin drivers; the pixel port follows write edges, not the level
	always_ff @(posedge clk_in) begin
		if (!reset_n_in || tg_hold) begin
			vsync_d <= 1'b0;
		end else begin
			vsync_d <= v_sync;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			crt_hsync_out                 <= 1'b0;
			crt_vertical_sync_pin_out     <= 1'b0;
			display_enable_out            <= 1'b0;
			panel_hsync_out               <= 1'b0;
			panel_vsync_out               <= 1'b0;
			pixel_port_enable_out         <= 1'b0;
			line_buffer_line_buffer_mode_a_out          <= 1'b0;
			line_buffer_use_read_addr_out <= 1'b0;
			line_buffer_wptr_reset_out    <= 1'b0;
		end else begin
			crt_hsync_out             <= next_crt_hpin;                                  // RULE_09
			crt_vertical_sync_pin_out <= next_crt_vpin;                                  // RULE_10
			display_enable_out        <= next_enable;                                    // RULE_08
			panel_hsync_out           <= panel_power_on_in && h_sync;                    // RULE_11
			panel_vsync_out           <= panel_power_on_in && v_sync;                    // RULE_11
			if (pixel_port_rise) begin
				pixel_port_enable_out <= 1'b1;                                           // RULE_12
			end else if (pixel_port_fall) begin
				pixel_port_enable_out <= 1'b0;                                           // RULE_12
			end
			line_buffer_line_buffer_mode_a_out          <= display_output_config[BIT_LINE_BUFFER_MODE_A];  // RULE_15
			line_buffer_use_read_addr_out <= display_output_config[BIT_LINE_BUFFER_MODE_A]
				&& display_output_config[BIT_LINE_BUFFER_RW_SELECT];                       // RULE_16
			line_buffer_wptr_reset_out    <= line_buffer_mode_a_rise;                                   // RULE_15
		end
	end
endmodule : display_output_control

/* File: hw/display_pkg.sv */
package display_pkg;
	// register byte offsets from the controller base address
	localparam logic [15:0] OFFSET_LOCK          = 16'h8300;
	localparam logic [15:0] OFFSET_GEN_CONFIG    = 16'h8304;
	localparam logic [15:0] OFFSET_OUTPUT_CONFIG = 16'h830c;
	localparam logic [15:0] OFFSET_H_TIMING      = 16'h8330;
	localparam logic [15:0] OFFSET_V_TIMING      = 16'h8334;
	localparam logic [15:0] OFFSET_IRQ_STATUS    = 16'h8340;
	localparam logic [15:0] OFFSET_IRQ_MASK      = 16'h8344;
	localparam logic [15:0] OFFSET_LINE_STATUS   = 16'h8348;

	// general configuration bit positions
	localparam int BIT_PIXEL_PORT_ENABLE   = 0;
	localparam int BIT_CRT_VERTICAL_SYNC_PIN_ENABLE    = 1;
	localparam int BIT_CRT_HSYNC_ENABLE    = 2;
	localparam int BIT_BLANK_OUTPUT_ENABLE = 3;
	localparam int BIT_SERIAL_ID_CLOCK     = 4;
	localparam int BIT_TIMING_GEN_ENABLE   = 5;
	localparam int BIT_VERT_IRQ_ENABLE     = 6;
	localparam int GEN_CONFIG_WIDTH        = 7;

	// output configuration bit positions; only the low bits are stored
	localparam int BIT_LINE_BUFFER_MODE_A     = 15;
	localparam int BIT_LINE_BUFFER_RW_SELECT  = 14;
	localparam int OUTPUT_CONFIG_WIDTH        = 20;

	// interrupt status bits
	localparam int IRQ_VERTICAL   = 0;
	localparam int IRQ_FRAME_WRAP = 1;
	localparam int IRQ_WIDTH      = 2;

	// timing register fields: active end, sync start, total (each 10 bits)
	localparam int TIMING_FIELD_WIDTH = 10;
	localparam int TIMING_ACTIVE_LSB  = 0;
	localparam int TIMING_SYNC_LSB    = 10;
	localparam int TIMING_TOTAL_LSB   = 20;
	localparam int TIMING_WIDTH       = 30;

	// unlock key; the value is arbitrary
	localparam logic [31:0] UNLOCK_KEY = 32'h0000_5a5a;

	localparam logic [GEN_CONFIG_WIDTH-1:0]    GEN_CONFIG_RESET    = 7'h00;
	localparam logic [OUTPUT_CONFIG_WIDTH-1:0] OUTPUT_CONFIG_RESET = 20'h00000;
	localparam logic [TIMING_WIDTH-1:0]        TIMING_RESET        = 30'h00000000;
	localparam logic [IRQ_WIDTH-1:0]           IRQ_RESET           = 2'h0;
	localparam logic                           LOCKED_RESET        = 1'b1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : display_pkg

/* File: hw/input_sync3.sv */
module input_sync3 (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	// asynchronous level and its settled copy
	input  wire logic async_in,
	output logic      level_out
);
	logic stage1;
	logic stage2;
	logic stage3;

	// the settled level only moves once the second and third stages agree
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			stage1    <= 1'b0;
			stage2    <= 1'b0;
			stage3    <= 1'b0;
			level_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				level_out <= stage3;
			end
		end
	end
endmodule : input_sync3

/* File: hw/timing_counter.sv */
module timing_counter #(
	parameter int WIDTH = 10
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	// control
	input  wire logic             hold_in,
	input  wire logic             advance_in,
	input  wire logic [WIDTH-1:0] total_in,
	// state
	output logic      [WIDTH-1:0] count_out,
	output logic                  wrap_out
);
	wire last_count = (count_out >= total_in);

	assign wrap_out = advance_in && last_count && !hold_in;

	always_ff @(posedge clk_in) begin
		if (!reset_n_in || hold_in) begin
			count_out <= '0;
		end else if (advance_in) begin
			count_out <= last_count ? '0 : count_out + 1'b1;
		end
	end
endmodule : timing_counter

/* File: testbench/display_output_control_assertions.sv */
module display_output_control_assertions (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	// register bus
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	// display side
	input wire logic        panel_power_on_in,
	input wire logic        panel_hsync_out,
	input wire logic        panel_vsync_out,
	input wire logic        pixel_port_enable_out,
	input wire logic        line_buffer_wptr_reset_out,
	input wire logic        irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	// config side effects only land around a write response, never on their own
	sequence wr_recent;
		s_axi_bvalid_out || $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2);
	endsequence
	AST_WR_RESP: assert property (wr_taken |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
		else $error("write response not two cycles after handshake");
	AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped early");
	AST_RD_RESP: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data not one cycle after address");
	AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped early");
	AST_BUSY_REFUSE: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write accepted while response pending");
	AST_PANEL_OFF: assert property (!panel_power_on_in [*3] |-> !panel_hsync_out && !panel_vsync_out)
		else $error("panel sync without panel power");
	AST_PPE_WRITE: assert property ($changed(pixel_port_enable_out) |-> wr_recent)
		else $error("pixel port changed without a write");
	AST_IRQ_FALL: assert property ($fell(irq_out) |-> wr_recent)
		else $error("interrupt dropped without a write");
	AST_WPTR_PULSE: assert property (line_buffer_wptr_reset_out |->
		wr_recent ##1 !line_buffer_wptr_reset_out)
		else $error("pointer reset not a single pulse after a write");
endmodule : display_output_control_assertions

bind display_output_control display_output_control_assertions display_output_control_assertions_inst (.*);

/* File: testbench/display_monitor_model.sv */
module display_monitor_model #(
	parameter logic [7:0] ID_BYTE = 8'ha6 // arbitrary identification pattern
) (
	// serial clock from the controller, data back to it
	input  wire logic serial_clock_in,
	output logic      serial_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] bit_idx = 3'h0;
	// one bit per rising clock, msb first; the display cannot tell sync from clock
	always @(posedge serial_clock_in) begin
		bit_idx <= bit_idx + 3'h1;
	end
	assign serial_data_out = ID_BYTE[3'h7 - bit_idx];
endmodule : display_monitor_model

/* File: testbench/tb_top.sv */
module tb_top
	import display_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ID = 8'ha6; // arbitrary pattern
	localparam logic WR = 1'b1;
	localparam logic RD = 1'b0;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [15:0] s_axi_awaddr_in = 16'h0, s_axi_araddr_in = 16'h0;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, d, seed = 32'h119f;
	logic [3:0]  s_axi_wstrb_in = 4'hf;
	logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, panel_power_on_in = 1'b0;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
	logic        serial_id_data_in, crt_hsync_out, crt_vertical_sync_pin_out, display_enable_out;
	logic        panel_hsync_out, panel_vsync_out, pixel_port_enable_out, irq_out;
	logic        line_buffer_line_buffer_mode_a_out, line_buffer_use_read_addr_out, line_buffer_wptr_reset_out;
	logic [5:0]  pins;
	int          error_cnt = 0, tests_run = 0, cyc = 0, rises = 0, pulses = 0, p0, i;
	int          cnt[6];
	assign pins = {irq_out, panel_vsync_out, panel_hsync_out, display_enable_out, crt_vertical_sync_pin_out,
		crt_hsync_out};
	display_output_control display_output_control_inst (.*);
	display_monitor_model #(.ID_BYTE(ID)) display_monitor_model_inst (
		.serial_clock_in(crt_vertical_sync_pin_out), .serial_data_out(serial_id_data_in));
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge crt_vertical_sync_pin_out) rises++;
	always @(negedge clk_in) pulses += int'(line_buffer_wptr_reset_out === 1'b1);
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	function automatic logic [31:0] tword(input int act, input int sync, input int tot);
		return {2'h0, tot[9:0], sync[9:0], act[9:0]};
	endfunction : tword
	// high cycles of a sync over ten frames
	function automatic int span(input int tot, input int sync, input int other_tot);
		return (tot + 1 - sync) * (other_tot + 1) * 10;
	endfunction : span
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr_en, input logic [15:0] a, input logic [31:0] wd);
		logic ta, tw, v, done;
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_araddr_in <= a;
		s_axi_wdata_in <= wd;
		s_axi_awvalid_in <= wr_en;
		s_axi_wvalid_in <= wr_en;
		// odd-word addresses hold ready back until the answer shows, so a waiting answer is exercised
		s_axi_bready_in <= wr_en & !a[2];
		s_axi_arvalid_in <= !wr_en;
		s_axi_rready_in <= !wr_en & !a[2];
		do begin
			@(negedge clk_in);
			ta = (s_axi_awvalid_in & s_axi_awready_out) | (s_axi_arvalid_in & s_axi_arready_out);
			tw = s_axi_wvalid_in & s_axi_wready_out;
			v = wr_en ? s_axi_bvalid_out : s_axi_rvalid_out;
			done = v & (wr_en ? s_axi_bready_in : s_axi_rready_in);
			r = wr_en ? s_axi_bresp_out : s_axi_rresp_out;
			d = s_axi_rdata_out;
			@(posedge clk_in);
			s_axi_awvalid_in <= s_axi_awvalid_in & ~ta;
			s_axi_arvalid_in <= s_axi_arvalid_in & ~ta;
			s_axi_wvalid_in <= s_axi_wvalid_in & ~tw;
			s_axi_bready_in <= wr_en & (v | !a[2]) & !done;
			s_axi_rready_in <= !wr_en & (v | !a[2]) & !done;
		end while (done !== 1'b1);
	endtask : bus
	task automatic watch(input int n);
		cnt = '{default: 0};
		repeat (n) begin
			@(negedge clk_in);
			for (int k = 0; k < 6; k++) cnt[k] += int'(pins[k] === 1'b1);
		end
	endtask : watch
	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (8) @(posedge clk_in);
		reset_n_in <= 1'b1;
		bus(RD, OFFSET_LOCK, 32'h0);
		chk(d, 32'h1);
		bus(RD, OFFSET_OUTPUT_CONFIG, 32'h0);
		chk(d, 32'h0);
		bus(WR, OFFSET_GEN_CONFIG, 32'h1);
		bus(RD, OFFSET_GEN_CONFIG, 32'h0);
		chk(d, 32'h0);
		bus(WR, OFFSET_LOCK, UNLOCK_KEY);
		seed = xorshift(seed);
		bus(WR, OFFSET_OUTPUT_CONFIG, seed);
		bus(RD, OFFSET_OUTPUT_CONFIG, 32'h0);
		chk(d, seed & 32'h000fffff);
		bus(WR, OFFSET_OUTPUT_CONFIG, 32'h0);
		p0 = pulses;
		bus(WR, OFFSET_OUTPUT_CONFIG, 32'h0000c000);
		watch(3);
		chk(pulses - p0, 1);
		chk(32'({line_buffer_line_buffer_mode_a_out, line_buffer_use_read_addr_out}), 32'h3);
		bus(WR, OFFSET_OUTPUT_CONFIG, 32'h00008000);
		watch(3);
		chk(pulses - p0, 1);
		chk(32'(line_buffer_use_read_addr_out), 32'h0);
		bus(RD, 16'h8400, 32'h0);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		for (i = 1; i >= 0; i--) begin
			bus(WR, OFFSET_GEN_CONFIG, 32'(i));
			watch(3);
			chk(32'(pixel_port_enable_out), 32'(i));
		end
		bus(WR, OFFSET_H_TIMING, tword(4, 6, 9));
		bus(WR, OFFSET_V_TIMING, tword(2, 3, 4));
		bus(RD, OFFSET_H_TIMING, 32'h0);
		chk(d, tword(4, 6, 9));
		bus(WR, OFFSET_IRQ_MASK, 32'h1);
		bus(WR, OFFSET_GEN_CONFIG, 32'h4e);
		watch(100);
		chk(cnt[0] + cnt[1] + cnt[2], 0);
		bus(WR, OFFSET_GEN_CONFIG, 32'h6e);
		seed = xorshift(seed);
		bus(WR, OFFSET_H_TIMING, seed);
		chk(32'(r), 32'(RESP_OKAY));
		bus(RD, OFFSET_H_TIMING, 32'h0);
		chk(d, tword(4, 6, 9));
		watch(60);
		watch(500);
		chk(cnt[0], span(9, 6, 4));
		chk(cnt[1], span(4, 3, 9));
		chk(cnt[2], 4 * 2 * 10);
		chk(cnt[3] + cnt[4], 0);
		chk(32'(irq_out), 32'h1);
		for (i = 0; i < 2; i++) begin
			bus(WR, OFFSET_IRQ_MASK, 32'(i));
			watch(2);
			chk(32'(irq_out), 32'(i));
		end
		bus(WR, OFFSET_GEN_CONFIG, 32'h20);
		panel_power_on_in <= 1'b1;
		bus(RD, OFFSET_IRQ_STATUS, 32'h0);
		chk(d & 32'h1, 32'h0);
		watch(60);
		watch(500);
		chk(cnt[0] + cnt[1] + cnt[2] + cnt[5], 0);
		chk(cnt[3] + cnt[4], span(9, 6, 4) + span(4, 3, 9));
		bus(WR, OFFSET_GEN_CONFIG, 32'h60);
		panel_power_on_in <= 1'b0;
		watch(100);
		chk(32'(irq_out), 32'h1);
		bus(WR, OFFSET_GEN_CONFIG, 32'h40);
		bus(WR, OFFSET_IRQ_STATUS, 32'h1);
		watch(2);
		chk(32'(irq_out), 32'h0);
		bus(WR, OFFSET_H_TIMING, tword(5, 7, 9));
		bus(RD, OFFSET_H_TIMING, 32'h0);
		chk(d, tword(5, 7, 9));
		// software-clocked identification read with normal vsync off
		for (i = 0; i < 8; i++) begin
			bus(WR, OFFSET_GEN_CONFIG, 32'h10);
			watch(3);
			chk(32'(crt_vertical_sync_pin_out), 32'h1);
			bus(WR, OFFSET_GEN_CONFIG, 32'h0);
			watch(8);
			bus(RD, OFFSET_LINE_STATUS, 32'h0);
			chk(32'(d[31]), 32'(ID[7 - rises % 8]));
		end
		conclude();
	end
endmodule : tb_top
